// [sim/bus_far_side.sv]
// Behavioural model of the instrument bus states seen by the decoder
`timescale 1ns/100ps
`default_nettype none
module bus_far_side (
	input  wire logic sys_clk,        // System clock
	input  wire logic rdy_msg,        // Ready message from the decoder
	output logic      acc_not_ready,  // Acceptor not ready
	output logic      listen_idle,    // Listener idle
	output logic      end_rx,         // End received flag
	output logic      byte_rcvd,      // Byte accepted pulse
	output logic      ctl_ppoll,      // Controller in poll
	output logic      ctl_idle        // Controller idle
);
	// ----------------------------------------------------------------
	// Bus state
	// ----------------------------------------------------------------
	initial begin
		{acc_not_ready, listen_idle, end_rx, byte_rcvd, ctl_ppoll, ctl_idle} = 6'h00;
	end

	// Acceptor leaves not-ready once ready has been granted
	always @(posedge sys_clk) begin
		if (rdy_msg === 1'b1) begin
			acc_not_ready <= #1 1'b0;
		end
	end

	// Fresh entry into the not-ready state: low for a cycle, then high
	task automatic anrs_enter();
		@(posedge sys_clk);
		#1 acc_not_ready = 1'b0;
		@(posedge sys_clk);
		#1 acc_not_ready = 1'b1;
	endtask

	// One received data byte, one cycle long
	task automatic send_byte();
		@(posedge sys_clk);
		#1 byte_rcvd = 1'b1;
		@(posedge sys_clk);
		#1 byte_rcvd = 1'b0;
	endtask

	// Listener idle, end flag, controller poll and controller idle levels
	task automatic set_lvl(input logic li, input logic er, input logic pp, input logic ci);
		@(posedge sys_clk);
		#1 {listen_idle, end_rx, ctl_ppoll, ctl_idle} = {li, er, pp, ci};
	endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking testbench of the auxiliary listen and system control decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import aux_cmd_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic             sys_clk, srst, cmd_wr;     // Clock, reset, write strobe
	logic [CMD_W-1:0] cmd_code;                  // Command code
	logic             anr, lid, erx, byt, cpp, cid; // Bus states
	logic             lmsg, umsg, rdy, hold, dset, cont, rpp, rsc, ifc, ren; // Outputs
	int               err_total, samples_checked; // Mismatch and check counts
	logic [4:0]       sc_codes [5] = '{5'h1E, 5'h16, 5'h17, 5'h1F, 5'h17}; // IFC/REN order

	// Clock, 8 ns period
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	aux_listen_ctrl u_dut (.sys_clk(sys_clk), .srst(srst), .cmd_wr(cmd_wr),
		.cmd_code(cmd_code), .acc_not_ready(anr), .listen_idle(lid), .end_rx(erx),
		.byte_rcvd(byt), .ctl_ppoll(cpp), .ctl_idle(cid), .listen_msg(lmsg),
		.unlisten_msg(umsg), .rdy_msg(rdy), .rfd_holdoff(hold), .data_in_flag_set(dset),
		.cont_mode(cont), .rpp_msg(rpp), .rsc_msg(rsc), .ifc_line(ifc), .ren_line(ren));
	bus_far_side u_bus (.sys_clk(sys_clk), .rdy_msg(rdy), .acc_not_ready(anr),
		.listen_idle(lid), .end_rx(erx), .byte_rcvd(byt), .ctl_ppoll(cpp), .ctl_idle(cid));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: %s", $time, what);
		end
	endtask

	// Wait n edges, then step past them
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// One command write; returns when its answer is visible
	task automatic wr(input logic [4:0] c);
		@(posedge sys_clk);
		#1 cmd_wr = 1'b1;
		cmd_code = c;
		cyc(1);
		cmd_wr = 1'b0;
	endtask

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_cont();
		wr(CMD_LCM);
		chk(lmsg, 1'b1, "listen pulse missing");
		chk(cont, 1'b1, "continuous mode not set");
		cyc(1);
		chk(lmsg, 1'b0, "listen pulse too long");
		u_bus.anrs_enter();
		cyc(1);
		chk(rdy, 1'b1, "ready not issued");
		cyc(1);
		chk(rdy, 1'b0, "ready too long");
		u_bus.send_byte();
		chk(dset, 1'b0, "data-in set in continuous mode");
		u_bus.set_lvl(1'b0, 1'b1, 1'b0, 1'b0);
		cyc(2);
		chk(hold, 1'b1, "holdoff not entered");
		u_bus.anrs_enter();
		cyc(1);
		chk(rdy, 1'b0, "ready during holdoff");
		u_bus.set_lvl(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(2);
		chk(cont, 1'b0, "idle kept continuous mode");
		chk(hold, 1'b0, "holdoff stuck");
		u_bus.set_lvl(1'b0, 1'b0, 1'b0, 1'b0);
		$display("test continuous done");
	endtask

	task automatic test_listen();
		wr(CMD_LCM);
		wr(CMD_LISTEN);
		chk(lmsg, 1'b1, "plain listen pulse missing");
		chk(cont, 1'b0, "plain listen kept continuous");
		u_bus.anrs_enter();
		cyc(1);
		chk(rdy, 1'b0, "ready outside continuous mode");
		u_bus.send_byte();
		chk(dset, 1'b1, "data-in not set");
		cyc(1);
		chk(dset, 1'b0, "data-in set too long");
		$display("test listen done");
	endtask

	// Back-to-back writes give back-to-back pulses
	task automatic test_unlisten();
		@(posedge sys_clk);
		#1 cmd_wr = 1'b1;
		cmd_code = CMD_LUN;
		cyc(1);
		chk(umsg, 1'b1, "first unlisten missing");
		cyc(1);
		cmd_wr = 1'b0;
		chk(umsg, 1'b1, "second unlisten missing");
		cyc(1);
		chk(umsg, 1'b0, "unlisten too long");
		// A code that this block does not decode
		wr(5'h18);
		chk(lmsg, 1'b0, "unknown code gave listen");
		chk(umsg, 1'b0, "unknown code gave unlisten");
		$display("test unlisten done");
	endtask

	// Poll request is set, held, and cleared by the poll state and by controller idle
	task automatic test_poll();
		wr(CMD_EPP);
		chk(rpp, 1'b1, "poll request not set");
		cyc(3);
		chk(rpp, 1'b1, "poll request not held");
		u_bus.set_lvl(1'b0, 1'b0, 1'b1, 1'b0);
		cyc(1);
		chk(rpp, 1'b0, "poll state kept request");
		u_bus.set_lvl(1'b0, 1'b0, 1'b0, 1'b0);
		wr(CMD_EPP);
		u_bus.set_lvl(1'b0, 1'b0, 1'b0, 1'b1);
		cyc(1);
		chk(rpp, 1'b0, "controller idle kept request");
		u_bus.set_lvl(1'b0, 1'b0, 1'b0, 1'b0);
		$display("test poll done");
	endtask

	// Bench acts as system controller and keeps the line hold times
	task automatic test_sysctl();
		foreach (sc_codes[i]) begin
			cyc(LINE_HOLD_CYC);
			wr(sc_codes[i]);
			chk(rsc, 1'b1, "system control not requested");
			if (sc_codes[i][0] == 1'b0) begin
				chk(ifc, sc_codes[i][CMD_BIT_SEL], "IFC level wrong");
			end else begin
				chk(ren, sc_codes[i][CMD_BIT_SEL], "REN level wrong");
			end
		end
		wr(CMD_DSC);
		chk(rsc, 1'b0, "system control not dropped");
		$display("test system control done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		srst = 1'b1;
		cmd_wr = 1'b0;
		cmd_code = 5'h00;
		err_total = 0;
		samples_checked = 0;
		cyc(16);
		srst = 1'b0;
		chk(|{lmsg, umsg, rdy, hold, dset, cont, rpp, rsc, ifc, ren}, 1'b0, "reset state");
		test_cont();
		test_listen();
		test_unlisten();
		test_poll();
		test_sysctl();
		complete_run();
	end

	initial begin
		#((5 * LINE_HOLD_CYC + 10000) * 8); // Five line commands with hold gaps, plus margin
		err_total++;
		$display("Error %0t: watchdog expired", $time);
		complete_run();
	end
endmodule
`default_nettype wire

// [verilog/aux_cmd_decode.sv]
// Command code decoder: one strobe per write
`timescale 1ns/100ps
`default_nettype none
module aux_cmd_decode (
	input  wire logic                     cmd_wr,     // Write strobe, one cycle
	input  wire logic [aux_cmd_pkg::CMD_W-1:0] cmd_code,   // Written command code
	aux_cmd_if.dec                        cmd         // Decoded strobes
);
	import aux_cmd_pkg::*;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Each strobe follows the write pulse, so one write acts once
	always_comb begin
		cmd.listen_stb = cmd_wr && (cmd_code == CMD_LISTEN);  // R17
		cmd.lcm_stb    = cmd_wr && (cmd_code == CMD_LCM);
		cmd.lun_stb    = cmd_wr && (cmd_code == CMD_LUN);
		cmd.epp_stb    = cmd_wr && (cmd_code == CMD_EPP);
		cmd.dsc_stb    = cmd_wr && (cmd_code == CMD_DSC);
		cmd.ifc_stb    = cmd_wr && match_no_b3(cmd_code, CMD_IFC);
		cmd.ren_stb    = cmd_wr && match_no_b3(cmd_code, CMD_REN);
		cmd.line_val   = cmd_code[CMD_BIT_SEL];
	end
endmodule
`default_nettype wire

// [verilog/aux_cmd_if.sv]
// Decoded command strobes passed from the decoder to the consumers
`timescale 1ns/100ps
`default_nettype none
interface aux_cmd_if;
	logic listen_stb;   // Plain listen written
	logic lcm_stb;      // Listen in continuous mode written
	logic lun_stb;      // Local unlisten written
	logic epp_stb;      // Execute parallel poll written
	logic ifc_stb;      // Set or clear IFC written
	logic ren_stb;      // Set or clear REN written
	logic dsc_stb;      // Disable system control written
	logic line_val;     // Value of command bit three

	// Decoder side
	modport dec (output listen_stb, lcm_stb, lun_stb, epp_stb, ifc_stb, ren_stb,
		dsc_stb, line_val);
	// Consumer side
	modport use_side (input listen_stb, lcm_stb, lun_stb, epp_stb, ifc_stb, ren_stb,
		dsc_stb, line_val);
endinterface
`default_nettype wire

// [verilog/aux_cmd_pkg.sv]
// Constants and helpers for the auxiliary listen/control command decoder
// Overview of operation
// R1 - Code 11011: listen pulse, enter continuous mode
// R2 - Plain listen: pulse only, no continuous mode
// R3 - Continuous: ready on not-ready entry unless end
// R4 - Continuous: end seen holds off ready
// R5 - Continuous: received byte sets no data-in flag
// R6 - Leave continuous on plain listen or idle
// R7 - Code 11100: one-cycle local unlisten pulse
// R8 - Code 11101: set and hold parallel poll request
// R9 - Clear poll request on poll or idle state
// R10 - Software: no poll request with standby together
// R11 - IFC commands: request control, IFC follows bit three
// R12 - Software: hold IFC 100 us before clearing
// R13 - REN commands: request control, REN follows bit three
// R14 - Software: REN false 100 us before setting
// R15 - Software: IFC/REN only as system controller
// R16 - Code 10100: drop system control request
// R17 - One action per write; reset clears modes
package aux_cmd_pkg;

	// ----------------------------------------------------------------
	// Command field
	// ----------------------------------------------------------------
	localparam int unsigned CMD_W       = 5;          // Command code width
	localparam int unsigned CMD_BIT_SEL = 3;          // Bit carrying the line value

	localparam logic [4:0] CMD_LISTEN   = 5'h13;     // Plain listen
	localparam logic [4:0] CMD_LCM      = 5'h1B;     // Listen, continuous mode
	localparam logic [4:0] CMD_LUN      = 5'h1C;     // Local unlisten
	localparam logic [4:0] CMD_EPP      = 5'h1D;     // Execute parallel poll
	localparam logic [4:0] CMD_DSC      = 5'h14;     // Disable system control
	localparam logic [4:0] CMD_IFC      = 5'h16;     // Set/clear IFC, bit 3 masked
	localparam logic [4:0] CMD_REN      = 5'h17;     // Set/clear REN, bit 3 masked
	localparam logic [4:0] CMD_B3_MASK  = 5'h17;     // Ignores the line value bit

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ       = 125;      // System clock rate
	localparam int unsigned LINE_HOLD_US  = 100;      // Least IFC/REN hold time
	localparam int unsigned LINE_HOLD_CYC = LINE_HOLD_US * CLK_MHZ;  // Least hold, cycles

	// Match a code against a pattern, ignoring the line value bit
	function automatic logic match_no_b3(input logic [4:0] code, input logic [4:0] pat);
		match_no_b3 = ((code & CMD_B3_MASK) == pat);
	endfunction

endpackage

// [verilog/aux_listen_ctrl.sv]
// Top of the auxiliary listen and system control command decoder
`timescale 1ns/100ps
`default_nettype none
module aux_listen_ctrl (
	input  wire logic                          sys_clk,        // System clock
	input  wire logic                          srst,           // Sync reset
	input  wire logic                          cmd_wr,         // Command write strobe
	input  wire logic [aux_cmd_pkg::CMD_W-1:0] cmd_code,       // Command code
	input  wire logic                          acc_not_ready,  // Acceptor not ready
	input  wire logic                          listen_idle,    // Listener idle
	input  wire logic                          end_rx,         // End received flag
	input  wire logic                          byte_rcvd,      // Byte accepted pulse
	input  wire logic                          ctl_ppoll,      // Controller in poll
	input  wire logic                          ctl_idle,       // Controller idle
	output logic                               listen_msg,     // Listen pulse
	output logic                               unlisten_msg,   // Unlisten pulse
	output logic                               rdy_msg,        // Ready pulse
	output logic                               rfd_holdoff,    // Ready holdoff
	output logic                               data_in_flag_set, // Data-in set pulse
	output logic                               cont_mode,      // Continuous mode
	output logic                               rpp_msg,        // Poll request
	output logic                               rsc_msg,        // System control req
	output logic                               ifc_line,       // IFC drive level
	output logic                               ren_line        // REN drive level
);
	import aux_cmd_pkg::*;

	// ----------------------------------------------------------------
	// Internal state
	// ----------------------------------------------------------------
	aux_cmd_if cmd ();          // Decoded strobes
	logic listen_ff;            // Listen pulse register
	logic unlisten_ff;          // Unlisten pulse register
	logic rpp_ff;               // Parallel poll request
	logic rsc_ff;               // System control request
	logic ifc_ff;               // IFC level
	logic ren_ff;               // REN level

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	aux_cmd_decode u_dec (
		.cmd_wr   (cmd_wr),
		.cmd_code (cmd_code),
		.cmd      (cmd)
	);

	cont_listen u_cont (
		.sys_clk        (sys_clk),
		.srst           (srst),
		.cmd            (cmd),
		.acc_not_ready  (acc_not_ready),
		.listen_idle    (listen_idle),
		.end_rx         (end_rx),
		.byte_rcvd      (byte_rcvd),
		.cont_ff        (cont_mode),
		.rdy_pulse_ff   (rdy_msg),
		.holdoff_ff     (rfd_holdoff),
		.data_in_set_ff (data_in_flag_set)
	);

	// ----------------------------------------------------------------
	// Listen pulses
	// ----------------------------------------------------------------
	// Both listen forms pulse the message for one cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			listen_ff <= 1'b0;
		end else begin
			listen_ff <= cmd.listen_stb || cmd.lcm_stb;    // R1 R2
		end
	end

	// Unlisten pulse
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			unlisten_ff <= 1'b0;
		end else begin
			unlisten_ff <= cmd.lun_stb;                    // R7
		end
	end

	// ----------------------------------------------------------------
	// Parallel poll request
	// ----------------------------------------------------------------
	// A new request beats a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rpp_ff <= 1'b0;                                // R17
		end else if (cmd.epp_stb) begin
			rpp_ff <= 1'b1;                                // R8
		end else if (ctl_ppoll || ctl_idle) begin
			rpp_ff <= 1'b0;                                // R9
		end
	end

	// ----------------------------------------------------------------
	// System control
	// ----------------------------------------------------------------
	// Any line command requests control; disable drops it
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rsc_ff <= 1'b0;                                // R17
		end else if (cmd.ifc_stb || cmd.ren_stb) begin
			rsc_ff <= 1'b1;                                // R11 R13
		end else if (cmd.dsc_stb) begin
			rsc_ff <= 1'b0;                                // R16
		end
	end

	// IFC follows the line value bit
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ifc_ff <= 1'b0;
		end else if (cmd.ifc_stb) begin
			ifc_ff <= cmd.line_val;                        // R11
		end
	end

	// REN follows the line value bit
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ren_ff <= 1'b0;
		end else if (cmd.ren_stb) begin
			ren_ff <= cmd.line_val;                        // R13
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		listen_msg   = listen_ff;
		unlisten_msg = unlisten_ff;
		rpp_msg      = rpp_ff;
		rsc_msg      = rsc_ff;
		ifc_line     = ifc_ff;
		ren_line     = ren_ff;
	end

	// ----------------------------------------------------------------
	// Checks: listen and continuous mode
	// ----------------------------------------------------------------
	// Pulse and entry; a second write may pulse again
	a_lcm_enters: assert property (@(posedge sys_clk) disable iff (srst) // R1
		cmd_wr && cmd_code == CMD_LCM
		|=> listen_msg && cont_mode ##1 (!listen_msg || $past(cmd_wr)))
		else $error("continuous listen not entered with one pulse");

	// Plain listen pulses and leaves the mode off
	a_listen_plain: assert property (@(posedge sys_clk) disable iff (srst) // R2
		cmd_wr && cmd_code == CMD_LISTEN |=> listen_msg && !cont_mode)
		else $error("plain listen left continuous mode on");

	// A listen pulse only follows a listen write
	a_listen_source: assert property (@(posedge sys_clk) disable iff (srst) // R1 R2
		listen_msg |-> $past(cmd.listen_stb) || $past(cmd.lcm_stb))
		else $error("listen pulse without a listen write");

	// The mode only starts on its own command
	a_cont_cause: assert property (@(posedge sys_clk) disable iff (srst) // R1
		cont_mode && !$past(cont_mode) |-> $past(cmd.lcm_stb))
		else $error("continuous mode entered without its command");

	// The mode stays until plain listen or idle
	a_cont_holds: assert property (@(posedge sys_clk) disable iff (srst) // R6
		cont_mode && !listen_idle && !cmd.listen_stb |=> cont_mode)
		else $error("continuous mode dropped early");

	// Ready on each fresh not-ready entry in continuous mode without end or holdoff
	a_auto_ready: assert property (@(posedge sys_clk) disable iff (srst) // R3
		cont_mode && !rfd_holdoff && !end_rx && acc_not_ready && !$past(acc_not_ready)
		|=> rdy_msg)
		else $error("no ready on not-ready entry");

	// Ready is a single-cycle pulse
	a_rdy_one_cycle: assert property (@(posedge sys_clk) disable iff (srst) // R3
		rdy_msg |=> !rdy_msg)
		else $error("ready longer than one cycle");

	// Ready only in continuous mode
	a_rdy_needs_cont: assert property (@(posedge sys_clk) disable iff (srst) // R3
		rdy_msg |-> $past(cont_mode))
		else $error("ready outside continuous mode");

	// End received blocks ready
	a_rdy_not_end: assert property (@(posedge sys_clk) disable iff (srst) // R3
		end_rx |=> !rdy_msg)
		else $error("ready with end received");

	// End in continuous mode enters the holdoff
	a_holdoff_set: assert property (@(posedge sys_clk) disable iff (srst) // R4
		cont_mode && end_rx |=> rfd_holdoff)
		else $error("holdoff not entered");

	// Holdoff only follows end in continuous mode
	a_holdoff_cause: assert property (@(posedge sys_clk) disable iff (srst) // R4
		rfd_holdoff |-> $past(cont_mode) && $past(end_rx))
		else $error("holdoff without end");

	// Outside the mode each byte sets data-in
	a_di_outside: assert property (@(posedge sys_clk) disable iff (srst) // R5
		!cont_mode && byte_rcvd |=> data_in_flag_set)
		else $error("data-in not set outside continuous mode");

	// Data-in only follows a received byte
	a_di_cause: assert property (@(posedge sys_clk) disable iff (srst) // R5
		data_in_flag_set |-> $past(byte_rcvd))
		else $error("data-in set without a byte");

	// Unlisten pulses once per write
	a_unlisten_pulse: assert property (@(posedge sys_clk) disable iff (srst) // R7
		cmd_wr && cmd_code == CMD_LUN |=> unlisten_msg ##1 (!unlisten_msg || $past(cmd.lun_stb)))
		else $error("unlisten not one cycle");

	// Unlisten only follows its own write
	a_unlisten_source: assert property (@(posedge sys_clk) disable iff (srst) // R7
		unlisten_msg |-> $past(cmd.lun_stb))
		else $error("unlisten without its write");

	// ----------------------------------------------------------------
	// Checks: poll and system control
	// ----------------------------------------------------------------
	// Poll request rises on its command
	a_rpp_set: assert property (@(posedge sys_clk) disable iff (srst) // R8
		cmd_wr && cmd_code == CMD_EPP |=> rpp_msg)
		else $error("poll request not set");

	// Request held while the controller stays away
	a_rpp_hold: assert property (@(posedge sys_clk) disable iff (srst) // R8
		cmd_wr && cmd_code == CMD_EPP ##1 (!ctl_ppoll && !ctl_idle) [*2] |-> rpp_msg)
		else $error("poll request not held");

	// Request kept until poll or idle state
	a_rpp_stays: assert property (@(posedge sys_clk) disable iff (srst) // R8
		rpp_msg && !ctl_ppoll && !ctl_idle |=> rpp_msg)
		else $error("poll request dropped early");

	// Request only rises on its command
	a_rpp_cause: assert property (@(posedge sys_clk) disable iff (srst) // R8
		rpp_msg && !$past(rpp_msg) |-> $past(cmd.epp_stb))
		else $error("poll request without its command");

	// Poll or idle state drops the request
	a_rpp_clear: assert property (@(posedge sys_clk) disable iff (srst) // R9
		(ctl_ppoll || ctl_idle) && !(cmd_wr && cmd_code == CMD_EPP) |=> !rpp_msg)
		else $error("poll request not cleared");

	// IFC follows bit three and requests control
	a_ifc_value: assert property (@(posedge sys_clk) disable iff (srst) // R11
		cmd_wr && match_no_b3(cmd_code, CMD_IFC)
		|=> rsc_msg && ifc_line == $past(cmd.line_val))
		else $error("IFC command wrong");

	// REN follows bit three and requests control
	a_ren_value: assert property (@(posedge sys_clk) disable iff (srst) // R13
		cmd_wr && match_no_b3(cmd_code, CMD_REN)
		|=> rsc_msg && ren_line == $past(cmd.line_val))
		else $error("REN command wrong");

	// IFC only moves on an IFC command
	a_ifc_holds: assert property (@(posedge sys_clk) disable iff (srst) // R11
		!cmd.ifc_stb |=> $stable(ifc_line))
		else $error("IFC moved without its command");

	// REN only moves on a REN command
	a_ren_holds: assert property (@(posedge sys_clk) disable iff (srst) // R13
		!cmd.ren_stb |=> $stable(ren_line))
		else $error("REN moved without its command");

	// Control request only rises on a line command
	a_rsc_cause: assert property (@(posedge sys_clk) disable iff (srst) // R11 R13
		rsc_msg && !$past(rsc_msg) |-> $past(cmd.ifc_stb) || $past(cmd.ren_stb))
		else $error("control request without a line command");

	// Only the disable command drops the request
	a_rsc_stays: assert property (@(posedge sys_clk) disable iff (srst) // R16
		rsc_msg && !cmd.dsc_stb |=> rsc_msg)
		else $error("control request dropped early");

	// Disable drops the request
	a_dsc_clears: assert property (@(posedge sys_clk) disable iff (srst) // R16
		cmd_wr && cmd_code == CMD_DSC |=> !rsc_msg)
		else $error("system control not dropped");

	// Disable leaves both lines alone
	a_disable_keeps_lines: assert property (@(posedge sys_clk) disable iff (srst) // R16
		cmd_wr && cmd_code == CMD_DSC |=> $stable(ifc_line) && $stable(ren_line))
		else $error("disable moved a line");

	// A code this block does not decode does nothing
	a_unknown_quiet: assert property (@(posedge sys_clk) disable iff (srst) // R17
		cmd_wr && !cmd.listen_stb && !cmd.lcm_stb && !cmd.lun_stb && !cmd.epp_stb
		&& !cmd.dsc_stb && !cmd.ifc_stb && !cmd.ren_stb
		|=> !listen_msg && !unlisten_msg && $stable(rsc_msg))
		else $error("unknown code had an effect");

	// Reset clears every mode and request
	a_reset_clear: assert property (@(posedge sys_clk) // R17
		srst |=> !cont_mode && !rpp_msg && !rsc_msg)
		else $error("reset left a mode set");

	// Main scenarios
	c_lcm: cover property (@(posedge sys_clk) disable iff (srst) cont_mode && listen_msg);
	c_rpp: cover property (@(posedge sys_clk) disable iff (srst) rpp_msg ##1 !rpp_msg);
	c_ifc: cover property (@(posedge sys_clk) disable iff (srst) ifc_line ##1 !ifc_line);
endmodule
`default_nettype wire

// [verilog/cont_listen.sv]
// Continuous listen mode: automatic ready and data-in suppression
`timescale 1ns/100ps
`default_nettype none
module cont_listen (
	input  wire logic sys_clk,        // System clock
	input  wire logic srst,           // Synchronous reset, active high
	aux_cmd_if.use_side cmd,          // Decoded strobes
	input  wire logic acc_not_ready,  // Acceptor in not-ready state
	input  wire logic listen_idle,    // Listener in idle state
	input  wire logic end_rx,         // End-of-block received flag
	input  wire logic byte_rcvd,      // Data byte accepted, one cycle
	output logic      cont_ff,        // Continuous mode active
	output logic      rdy_pulse_ff,   // Ready local message pulse
	output logic      holdoff_ff,     // Ready-for-data holdoff
	output logic      data_in_set_ff  // Sets the data-in flag, one cycle
);
	import aux_cmd_pkg::*;

	logic anr_d_ff;   // Not-ready state one cycle ago

	// ----------------------------------------------------------------
	// Mode
	// ----------------------------------------------------------------
	// Entry beats an exit in the same cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cont_ff <= 1'b0;                               // R17
		end else if (cmd.lcm_stb) begin
			cont_ff <= 1'b1;                               // R1
		end else if (cmd.listen_stb || listen_idle) begin
			cont_ff <= 1'b0;                               // R6
		end
	end

	// Edge of the not-ready state
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			anr_d_ff <= 1'b0;
		end else begin
			anr_d_ff <= acc_not_ready;
		end
	end

	// Ready pulse on entry, blocked by end or holdoff
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdy_pulse_ff <= 1'b0;
		end else begin
			rdy_pulse_ff <= cont_ff && acc_not_ready && !anr_d_ff
				&& !end_rx && !holdoff_ff;                     // R3
		end
	end

	// Holdoff follows end seen in continuous mode
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			holdoff_ff <= 1'b0;
		end else if (cont_ff && end_rx) begin
			holdoff_ff <= 1'b1;                            // R4
		end else if (!cont_ff || !end_rx) begin
			holdoff_ff <= 1'b0;
		end
	end

	// Data-in flag set only outside continuous mode
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			data_in_set_ff <= 1'b0;
		end else begin
			data_in_set_ff <= byte_rcvd && !cont_ff;       // R5
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_no_di_cont: assert property (@(posedge sys_clk) disable iff (srst) // R5
		cont_ff && byte_rcvd |=> !data_in_set_ff)
		else $error("data-in set in continuous mode");
	a_holdoff_blocks: assert property (@(posedge sys_clk) disable iff (srst) // R4
		holdoff_ff |=> !rdy_pulse_ff)
		else $error("ready during holdoff");
	a_idle_exits: assert property (@(posedge sys_clk) disable iff (srst) // R6
		listen_idle && !cmd.lcm_stb |=> !cont_ff)
		else $error("continuous mode kept in idle");
	c_auto_ready: cover property (@(posedge sys_clk) disable iff (srst) rdy_pulse_ff);
	c_holdoff: cover property (@(posedge sys_clk) disable iff (srst) holdoff_ff);
endmodule
`default_nettype wire
